// ### hdl/bpls_pkg.sv
// Package: constants and carrier types for byte parity and lane steering
package bpls_pkg;
    // ****************************************
    // Geometry
    // ****************************************
    localparam int ADDR_W = 16;               // 64K locations per parity memory
    localparam int LANES = 2;                 // Even and odd byte lanes
    localparam int PAIRS = 2;                 // Two even and two odd banks
    localparam int PAR_DEPTH = PAIRS * LANES * (1 << ADDR_W);
    localparam int PAR_IDX_W = ADDR_W + 2;
    localparam logic [0:0] LANE_EVEN = 1'h0;
    localparam logic [0:0] LANE_ODD = 1'h1;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam int CTRL_INHIBIT_N_BIT = 4;    // Zero forces parity write inhibit
    localparam int CTRL_KILL_N_BIT = 5;       // Zero kills the parity interrupt
    localparam logic [31:0] CTRL_RESET = 32'h0000_0030;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0030;
    localparam int ST_LATCH_BIT = 0;          // Sticky error status, write one to clear
    localparam int ST_ERRFF_BIT = 1;          // Error flip-flop state
    localparam int ST_LANE_LO = 2;            // Last lane error pair, two bits

    // ****************************************
    // Carrier for the memory cycle controls
    // ****************************************
    typedef struct packed {
        logic a0;                // Byte address bit zero
        logic sixteen_req;       // Word transfer request, active high
        logic data_in_strobe;    // Bus read strobe
        logic mem_write_strobe;  // On-card write cycle
        logic read_cycle;        // On-card read cycle in progress
        logic ras;               // Row strobe, one-cycle pulse
        logic cas;               // Column strobe, one-cycle pulse
        logic pair;              // Which even/odd bank pair
    } bpls_cyc_t;
endpackage : bpls_pkg

// ### hdl/bpls_core.sv
// Byte parity generation and checking with 8/16-bit lane steering behind an APB slave
`timescale 1ns/1ps
// How it works
// (R1) One parity bit per byte in 64K memories
// (R2) Parity memory uses data memory row/column strobes
// (R3) Own gated parity write enable, private data path
// (R4) Nine-input parity per lane, even and odd
// (R5) Even output high for even count
// (R6) Write input one: odd byte stores zero
// (R7) Even byte stores one, total stays odd
// (R8) Even count on read is an error
// (R9) Odd count on read: error stays low
// (R10) Error gated by check window near read end
// (R11) Window rise with error sets error flip-flop
// (R12) Kill bit zero holds error flip-flop clear
// (R13) Error also sets readable status latch
// (R14) Write inhibit keeps stale parity for test
// (R15) Writing zero to D4 forces inhibit
// (R16) Steering from a0, word request, strobes
// (R17) a0 picks even/odd; word request selects word
// (R18) Two odd, two even banks
// (R19) Byte write routes DO to chosen bank
// (R20) Byte read drives chosen bank onto DI
// (R21) Word read: even on DO, odd on DI
// (R22) Word write: both bytes in same cycle
// (R23) Word-only hosts avoid single-bank setup
// (R24) Error stays until killed or reset
module bpls_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire bpls_pkg::bpls_cyc_t cyc,
    input wire logic [7:0] row_col_addr,
    input wire logic check_window_enable,
    input wire logic [7:0] bus_do_in,
    input wire logic [7:0] bus_di_in,
    input wire logic [7:0] ram_even_rd,
    input wire logic [7:0] ram_odd_rd,
    output logic [7:0] bus_do_out,
    output logic bus_do_oe,
    output logic [7:0] bus_di_out,
    output logic bus_di_oe,
    output logic [7:0] ram_even_wr,
    output logic [7:0] ram_odd_wr,
    output logic [1:0] ram_we,
    output logic [1:0] par_we,
    output logic [1:0] par_wbit,
    output logic [1:0] lane_err,
    output logic error_n,
    output logic err_status
);

    // ****************************************
    // Functions
    // ****************************************
    // Nine-input parity: {even, odd}
    function automatic logic [1:0] parity9(input logic [7:0] d, input logic p);
        logic odd;
        odd = ^{d, p};
        return {~odd, odd}; // R4 R5
    endfunction : parity9

    // Even output alone: high when the nine inputs hold an even count
    function automatic logic par_even(input logic [7:0] d, input logic p);
        logic [1:0] eo;
        eo = parity9(d, p);
        return eo[1]; // R4 R5
    endfunction : par_even

    // Odd output alone: the bit to store so the nine bits stay odd
    function automatic logic par_odd(input logic [7:0] d, input logic p);
        logic [1:0] eo;
        eo = parity9(d, p);
        return eo[0]; // R4 R5
    endfunction : par_odd

    function automatic logic [bpls_pkg::PAR_IDX_W-1:0] par_idx(
        input logic pair, input logic lane, input logic [bpls_pkg::ADDR_W-1:0] a);
        return {pair, lane, a};
    endfunction : par_idx

    // ****************************************
    // Declarations
    // ****************************************
    logic par_mem [0:bpls_pkg::PAR_DEPTH-1];
    logic [31:0] ctrl_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [7:0] row_r;
    logic [1:0] par_rd_r;
    logic [1:0] lane_act_r;
    logic [1:0] lane_err_r;
    logic cwe_q_r;
    logic error_ff_r;
    logic error_n_r;
    logic status_r;
    logic [7:0] do_out_r;
    logic do_oe_r;
    logic [7:0] di_out_r;
    logic di_oe_r;
    logic [7:0] even_wr_r;
    logic [7:0] odd_wr_r;
    logic [1:0] ram_we_r;
    logic [1:0] par_we_r;
    logic [1:0] par_wbit_r;
    logic inhibit;
    logic kill_n;
    logic [1:0] lane_sel;
    logic [7:0] lane_wd [0:1];
    logic [bpls_pkg::ADDR_W-1:0] mem_addr;
    logic cwe_rise;
    logic any_err;
    logic wr_access;
    logic rd_setup;
    logic status_clr;

    // ****************************************
    // Decode
    // ****************************************
    // Control bits are active low as seen by software
    assign inhibit = ~ctrl_r[bpls_pkg::CTRL_INHIBIT_N_BIT]; // R14 R15
    assign kill_n = ctrl_r[bpls_pkg::CTRL_KILL_N_BIT]; // R12
    // Word request opens both lanes, else a0 picks one
    assign lane_sel[0] = cyc.sixteen_req | ~cyc.a0; // R16 R17
    assign lane_sel[1] = cyc.sixteen_req | cyc.a0; // R16 R17
    // Byte writes feed DO to both banks; word writes split DO and DI
    assign lane_wd[0] = bus_do_in; // R19 R22
    assign lane_wd[1] = cyc.sixteen_req ? bus_di_in : bus_do_in; // R19 R22
    assign mem_addr = {row_r, row_col_addr}; // R2
    assign cwe_rise = check_window_enable & ~cwe_q_r & cyc.read_cycle; // R10
    assign any_err = |(lane_err_r & lane_act_r);
    assign wr_access = psel & penable & pready_r & pwrite;
    assign rd_setup = psel & ~penable;
    assign status_clr = wr_access && paddr == bpls_pkg::OFS_STATUS
        && pwdata[bpls_pkg::ST_LATCH_BIT];

    // ****************************************
    // APB slave
    // ****************************************
    // Answer in the cycle after setup: one access cycle, no waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'h0;
            pslverr_r <= 1'h0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= rd_setup;
            pslverr_r <= rd_setup && paddr != bpls_pkg::OFS_CTRL
                && paddr != bpls_pkg::OFS_STATUS;
            prdata_r <= 32'h0000_0000;
            if (rd_setup && !pwrite) begin
                if (paddr == bpls_pkg::OFS_CTRL) begin
                    prdata_r <= ctrl_r;
                end else if (paddr == bpls_pkg::OFS_STATUS) begin
                    prdata_r[bpls_pkg::ST_LATCH_BIT] <= status_r; // R13
                    prdata_r[bpls_pkg::ST_ERRFF_BIT] <= error_ff_r;
                    prdata_r[bpls_pkg::ST_LANE_LO +: 2] <= lane_err_r;
                end
            end
        end
    end

    // Control port: only the inhibit and kill bits (D4, D5) are kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= bpls_pkg::CTRL_RESET;
        end else if (wr_access && paddr == bpls_pkg::OFS_CTRL) begin
            ctrl_r <= pwdata & bpls_pkg::CTRL_MASK; // R12 R15
        end
    end

    // ****************************************
    // Parity memories
    // ****************************************
    // Row latched on the row strobe, like the data array
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_r <= 8'h00;
        end else if (cyc.ras) begin
            row_r <= row_col_addr; // R2
        end
    end

    // Access on the column strobe; refresh is row-only and never touches parity
    always_ff @(posedge pclk) begin
        for (int l = 0; l < bpls_pkg::LANES; l++) begin
            if (cyc.cas && cyc.mem_write_strobe && lane_sel[l] && !inhibit) begin
                par_mem[par_idx(cyc.pair, l[0], mem_addr)] <= par_odd(lane_wd[l], 1'h1); // R1 R6 R7
            end
        end
    end

    // Stored bits come back on the private path, not the data bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            par_rd_r <= 2'h0;
            lane_act_r <= 2'h0;
        end else if (cyc.cas && !cyc.mem_write_strobe) begin
            for (int l = 0; l < bpls_pkg::LANES; l++) begin
                par_rd_r[l] <= par_mem[par_idx(cyc.pair, l[0], mem_addr)]; // R3
            end
            lane_act_r <= lane_sel;
        end
    end

    // Write enables and generated bits toward the parity memories
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            par_we_r <= 2'h0;
            par_wbit_r <= 2'h0;
        end else begin
            for (int l = 0; l < bpls_pkg::LANES; l++) begin
                par_we_r[l] <= cyc.cas & cyc.mem_write_strobe & lane_sel[l] & ~inhibit; // R3 R14
                par_wbit_r[l] <= par_odd(lane_wd[l], 1'h1); // R6 R7
            end
        end
    end

    // ****************************************
    // Checking
    // ****************************************
    // Even output of each lane flags an error; odd count keeps it low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_err_r <= 2'h0;
            cwe_q_r <= 1'h0;
        end else begin
            cwe_q_r <= check_window_enable;
            lane_err_r[0] <= par_even(ram_even_rd, par_rd_r[0]); // R8 R9
            lane_err_r[1] <= par_even(ram_odd_rd, par_rd_r[1]); // R8 R9
        end
    end

    // Kill holds the flop clear and beats a set; error is sticky otherwise
    // The bus line keeps its own low-active copy so the pin leaves a flop directly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_ff_r <= 1'h0;
            error_n_r <= 1'h1;
        end else if (!kill_n) begin
            error_ff_r <= 1'h0; // R12
            error_n_r <= 1'h1; // R12
        end else if (cwe_rise && any_err) begin
            error_ff_r <= 1'h1; // R11
            error_n_r <= 1'h0; // R11
        end
    end // R24

    // Status latch for board identification; a new error beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= 1'h0;
        end else if (cwe_rise && any_err) begin
            status_r <= 1'h1; // R13
        end else if (status_clr) begin
            status_r <= 1'h0;
        end
    end

    // ****************************************
    // Lane steering
    // ****************************************
    // Reads: byte to DI from chosen bank; word puts even on DO, odd on DI
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            do_out_r <= 8'h00;
            do_oe_r <= 1'h0;
            di_out_r <= 8'h00;
            di_oe_r <= 1'h0;
        end else begin
            do_oe_r <= cyc.data_in_strobe & cyc.sixteen_req; // R21
            di_oe_r <= cyc.data_in_strobe; // R20 R21
            do_out_r <= ram_even_rd; // R21
            di_out_r <= (cyc.sixteen_req || cyc.a0) ? ram_odd_rd : ram_even_rd; // R17 R20
        end
    end

    // Writes: data and per-bank enables for the two-by-two array
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            even_wr_r <= 8'h00;
            odd_wr_r <= 8'h00;
            ram_we_r <= 2'h0;
        end else begin
            even_wr_r <= lane_wd[0]; // R19 R22
            odd_wr_r <= lane_wd[1]; // R19 R22
            ram_we_r <= {2{cyc.mem_write_strobe}} & lane_sel; // R16 R18
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign bus_do_out = do_out_r;
    assign bus_do_oe = do_oe_r;
    assign bus_di_out = di_out_r;
    assign bus_di_oe = di_oe_r;
    assign ram_even_wr = even_wr_r;
    assign ram_odd_wr = odd_wr_r;
    assign ram_we = ram_we_r;
    assign par_we = par_we_r;
    assign par_wbit = par_wbit_r;
    assign lane_err = lane_err_r;
    assign error_n = error_n_r; // Bus error line, low while latched
    assign err_status = status_r;

    // ****************************************
    // Assertions
    // ****************************************
    property p_par_gen;
        @(posedge pclk) disable iff (!presetn)
        cyc.cas && cyc.mem_write_strobe |=> par_wbit_r[0] == ~^$past(bus_do_in);
    endproperty
    a_par_gen: assert property (p_par_gen) else $error("parity bit wrong"); // R6

    property p_par_inhibit;
        @(posedge pclk) disable iff (!presetn)
        inhibit |=> par_we_r == 2'h0;
    endproperty
    a_par_inhibit: assert property (p_par_inhibit) else $error("parity write not inhibited"); // R14

    property p_lane_chk;
        @(posedge pclk) disable iff (!presetn)
        1'h1 |=> lane_err_r[1] == ~^{$past(ram_odd_rd), $past(par_rd_r[1])};
    endproperty
    a_lane_chk: assert property (p_lane_chk) else $error("lane check wrong"); // R8

    property p_set;
        @(posedge pclk) disable iff (!presetn)
        cwe_rise && any_err && kill_n |=> !error_n;
    endproperty
    a_set: assert property (p_set) else $error("error not raised"); // R11

    property p_kill;
        @(posedge pclk) disable iff (!presetn)
        !kill_n |=> !error_ff_r;
    endproperty
    a_kill: assert property (p_kill) else $error("kill ignored"); // R12

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        error_ff_r && kill_n |=> error_ff_r;
    endproperty
    a_hold: assert property (p_hold) else $error("error dropped"); // R24

    property p_window;
        @(posedge pclk) disable iff (!presetn)
        $rose(error_ff_r) |-> $past(cwe_rise) && $past(any_err);
    endproperty
    a_window: assert property (p_window) else $error("error outside window"); // R10

    property p_status;
        @(posedge pclk) disable iff (!presetn)
        $rose(error_ff_r) |-> status_r;
    endproperty
    a_status: assert property (p_status) else $error("status not set"); // R13

    property p_byte_rd;
        @(posedge pclk) disable iff (!presetn)
        cyc.data_in_strobe && !cyc.sixteen_req && !cyc.a0 |=> bus_di_oe && !bus_do_oe
            && bus_di_out == $past(ram_even_rd);
    endproperty
    a_byte_rd: assert property (p_byte_rd) else $error("byte read steering wrong"); // R20

    property p_word_rd;
        @(posedge pclk) disable iff (!presetn)
        cyc.data_in_strobe && cyc.sixteen_req |=> bus_do_oe && bus_di_oe
            && bus_di_out == $past(ram_odd_rd);
    endproperty
    a_word_rd: assert property (p_word_rd) else $error("word read steering wrong"); // R21

    property p_word_wr;
        @(posedge pclk) disable iff (!presetn)
        cyc.mem_write_strobe && cyc.sixteen_req |=> ram_we == 2'h3 && ram_odd_wr == $past(bus_di_in);
    endproperty
    a_word_wr: assert property (p_word_wr) else $error("word write steering wrong"); // R22

endmodule : bpls_core

// ### bench/bpls_ram_model.sv
// Behavioural even and odd data banks at the far side of the steering logic
`timescale 1ns/1ps
module bpls_ram_model (
    input wire logic pclk,
    input wire bpls_pkg::bpls_cyc_t cyc,
    input wire logic [7:0] row_col_addr,
    input wire logic [7:0] ram_even_wr,
    input wire logic [7:0] ram_odd_wr,
    input wire logic [1:0] ram_we,
    output logic [7:0] ram_even_rd,
    output logic [7:0] ram_odd_rd
);
    // ****************************************
    // Bank storage
    // ****************************************
    logic [7:0] bank_e [0:131071];
    logic [7:0] bank_o [0:131071];
    logic [7:0] row_r = 8'h00;
    logic [7:0] col_r = 8'h00;
    logic col_ok = 1'h0;
    logic [16:0] key;

    // Banks start cleared so the checker never sees unknown bytes
    initial begin
        for (int i = 0; i < 131072; i++) begin
            bank_e[i] = 8'h00;
            bank_o[i] = 8'h00;
        end
    end

    // Pair bit picks one of the two even and two odd banks
    assign key = {cyc.pair, row_r, col_r};

    // Row then column strobe; no store before a column, so stale columns stay intact
    always @(posedge pclk) begin
        if (cyc.ras) begin
            row_r <= row_col_addr;
            col_ok <= 1'h0;
        end
        if (cyc.cas) begin
            col_r <= row_col_addr;
            col_ok <= 1'h1;
        end
        if (col_ok && ram_we[0]) begin
            bank_e[key] <= ram_even_wr;
        end
        if (col_ok && ram_we[1]) begin
            bank_o[key] <= ram_odd_wr;
        end
    end

    // Outside a read the outputs are inverted, so stale data never looks valid
    assign ram_even_rd = cyc.read_cycle ? bank_e[key] : ~bank_e[key];
    assign ram_odd_rd = cyc.read_cycle ? bank_o[key] : ~bank_o[key];
endmodule : bpls_ram_model

// ### bench/bpls_tb_top.sv
// Self-checking bench for APB control, byte and word steering and the parity error path
`timescale 1ns/1ps
module byte_parity_and_lane_steering_tb_top;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, bus_do_oe, bus_di_oe, error_n, err_status;
    bpls_pkg::bpls_cyc_t cyc = '0;
    logic [7:0] row_col_addr = 8'h00, bus_do_in = 8'h00, bus_di_in = 8'h00;
    logic [7:0] ram_even_rd, ram_odd_rd, bus_do_out, bus_di_out, ram_even_wr, ram_odd_wr;
    logic [1:0] ram_we, par_we, par_wbit, lane_err, pwe, pwb;
    logic check_window_enable = 1'h0;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    always #25 pclk = ~pclk;

    bpls_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cyc(cyc),
        .row_col_addr(row_col_addr), .check_window_enable(check_window_enable), .bus_do_in(bus_do_in),
        .bus_di_in(bus_di_in), .ram_even_rd(ram_even_rd), .ram_odd_rd(ram_odd_rd), .bus_do_out(bus_do_out),
        .bus_do_oe(bus_do_oe), .bus_di_out(bus_di_out), .bus_di_oe(bus_di_oe), .ram_even_wr(ram_even_wr),
        .ram_odd_wr(ram_odd_wr), .ram_we(ram_we), .par_we(par_we), .par_wbit(par_wbit),
        .lane_err(lane_err), .error_n(error_n), .err_status(err_status));

    bpls_ram_model ram (.pclk(pclk), .cyc(cyc), .row_col_addr(row_col_addr), .ram_even_wr(ram_even_wr),
        .ram_odd_wr(ram_odd_wr), .ram_we(ram_we), .ram_even_rd(ram_even_rd), .ram_odd_rd(ram_odd_rd));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finish_test;
        $display("Checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // Four-state compare so an unknown never counts as a match
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 16) num_errors++;
    endtask : apb

    // Row strobe, column strobe, then hold the cycle while results settle
    task automatic mem_start(input logic wr, a0, word, input logic [7:0] col, dout, din);
        @(posedge pclk);
        cyc <= '{a0: a0, sixteen_req: word, data_in_strobe: !wr, mem_write_strobe: wr, read_cycle: !wr,
                 ras: 1'h1, cas: 1'h0, pair: 1'h0};
        row_col_addr <= 8'h12;
        bus_do_in <= dout;
        bus_di_in <= din;
        @(posedge pclk);
        cyc.ras <= 1'h0;
        cyc.cas <= 1'h1;
        row_col_addr <= col;
        @(posedge pclk);
        cyc.cas <= 1'h0;
        #1;
        pwe = par_we;
        pwb = par_wbit;
        repeat (3) @(posedge pclk);
        #1;
    endtask : mem_start

    // Check window near the end of the cycle, then end the cycle and invert the bus inputs
    task automatic mem_end;
        @(posedge pclk);
        check_window_enable <= 1'h1;
        repeat (2) @(posedge pclk);
        check_window_enable <= 1'h0;
        cyc <= '0;
        bus_do_in <= ~bus_do_in;
        bus_di_in <= ~bus_di_in;
        @(posedge pclk);
        #1;
    endtask : mem_end

    task automatic wr_check(input logic a0, word, input logic [7:0] col, dout, din, input logic [1:0] we, pe, wb);
        mem_start(1'h1, a0, word, col, dout, din);
        chk("ram_we", ram_we, we);
        chk("bus_oe", {bus_do_oe, bus_di_oe}, 2'h0);
        if (we[0]) chk("ram_even_wr", ram_even_wr, dout);
        if (we[1]) chk("ram_odd_wr", ram_odd_wr, word ? din : dout);
        chk("par_we", pwe, pe);
        chk("par_wbit", pwb & we, wb & we);
        mem_end;
        chk("error_n", error_n, 1'h1);
    endtask : wr_check

    task automatic rd_check(input logic a0, word, input logic [7:0] col, edo, edi, input logic [1:0] oe, le, en);
        mem_start(1'h0, a0, word, col, 8'h00, 8'h00);
        chk("bus_oe", {bus_do_oe, bus_di_oe}, oe);
        if (oe[1]) chk("bus_do_out", bus_do_out, edo);
        chk("bus_di_out", bus_di_out, edi);
        chk("lane_err", lane_err, le);
        chk("error_n", error_n, 1'h1);
        mem_end;
        chk("error_n", error_n, en[0]);
    endtask : rd_check

    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            finish_test;
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        #1;
        chk("error_n", error_n, 1'h1);
        apb(bpls_pkg::OFS_CTRL, 1'h0, 32'h0);
        chk("ctrl", rdat, 32'h30);
        apb(12'h008, 1'h0, 32'h0);
        chk("pslverr", rerr, 1'h1);
        chk("prdata", rdat, 32'h0);
        apb(bpls_pkg::OFS_CTRL, 1'h1, 32'hFFFFFFFF);
        apb(bpls_pkg::OFS_CTRL, 1'h0, 32'h0);
        chk("ctrl", rdat, 32'h30);
        wr_check(1'h0, 1'h0, 8'h34, 8'h07, 8'hF8, 2'h1, 2'h1, 2'h0);
        wr_check(1'h1, 1'h0, 8'h34, 8'h03, 8'hFC, 2'h2, 2'h2, 2'h2);
        wr_check(1'h0, 1'h1, 8'h35, 8'h11, 8'h3C, 2'h3, 2'h3, 2'h3);
        rd_check(1'h0, 1'h0, 8'h34, 8'h00, 8'h07, 2'h1, 2'h0, 1'h1);
        rd_check(1'h1, 1'h0, 8'h34, 8'h00, 8'h03, 2'h1, 2'h0, 1'h1);
        rd_check(1'h0, 1'h1, 8'h35, 8'h11, 8'h3C, 2'h3, 2'h0, 1'h1);
        // Inhibited write leaves the old parity bit, so the read must fail
        apb(bpls_pkg::OFS_CTRL, 1'h1, 32'h20);
        wr_check(1'h0, 1'h0, 8'h34, 8'h0F, 8'hF0, 2'h1, 2'h0, 2'h1);
        apb(bpls_pkg::OFS_CTRL, 1'h1, 32'h30);
        rd_check(1'h0, 1'h0, 8'h34, 8'h00, 8'h0F, 2'h1, 2'h1, 1'h0);
        chk("err_status", err_status, 1'h1);
        repeat (20) @(posedge pclk);
        chk("error_n", error_n, 1'h0);
        apb(bpls_pkg::OFS_STATUS, 1'h0, 32'h0);
        chk("status", rdat & 32'h3, 32'h3);
        apb(bpls_pkg::OFS_CTRL, 1'h1, 32'h10);
        repeat (2) @(posedge pclk);
        #1;
        chk("error_n", error_n, 1'h1);
        rd_check(1'h0, 1'h0, 8'h34, 8'h00, 8'h0F, 2'h1, 2'h1, 1'h1);
        apb(bpls_pkg::OFS_STATUS, 1'h0, 32'h0);
        chk("status", rdat & 32'h3, 32'h1);
        apb(bpls_pkg::OFS_STATUS, 1'h1, 32'h1);
        apb(bpls_pkg::OFS_STATUS, 1'h0, 32'h0);
        chk("status", rdat & 32'h3, 32'h0);
        finish_test;
    end
endmodule : byte_parity_and_lane_steering_tb_top
